/* File: hdl/rasm_map.sv */
// Peripheral window decode and field access semantics
`timescale 1ns/1ps
`default_nettype none
module rasm_map #(
	parameter int GPIO_COUNT = 128
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        req,
	input  wire logic        wr,
	input  wire logic [31:0] addr,
	input  wire logic [31:0] wdata,
	input  wire logic [31:0] ro_status,
	output logic             ack,
	output logic [31:0]      rdata,
	output logic [2:0]       win_sel,
	output logic [31:0]      rw_ctrl,
	output logic [31:0]      wo_cmd,
	output logic             wo_cmd_pulse
);
	// Index field is addr[11:2], so at most 1024 words
	if (GPIO_COUNT < 2 || GPIO_COUNT > 1024) begin : gen_count_check
		$error("GPIO_COUNT out of range");
	end
	localparam int IW = $clog2(GPIO_COUNT);
	rasm_gpio_if #(.GPIO_COUNT(GPIO_COUNT)) gpio ();
	rasm_gpio_mem #(.GPIO_COUNT(GPIO_COUNT)) u_gpio (
		.clk   (clk),
		.rst_n (rst_n),
		.port  (gpio.mem)
	);
	rasm_pkg::rasm_win_t win;
	logic [7:0]  off;
	logic        in_gpio;
	logic        rd;
	logic        wrs;
	logic [31:0] sor;
	logic [31:0] cor;
	logic [31:0] w1c;
	logic [31:0] w0c;
	logic [31:0] w1s;
	logic [31:0] w0s;
	logic [31:0] test_reg;
	logic        gpio_rd;
	logic [31:0] next_rdata;
	assign off = addr[7:0];
	assign rd  = req && !wr;
	assign wrs = req && wr;
	always_comb begin
		in_gpio = 1'b0;
		if ((addr & rasm_pkg::WIN_MASK) == rasm_pkg::WDT_BASE) begin
			win = rasm_pkg::RASM_WIN_WDT;
		end else if ((addr & rasm_pkg::WIN_MASK) == rasm_pkg::DEBUG_BASE) begin
			win = rasm_pkg::RASM_WIN_DEBUG;
		end else if ((addr & rasm_pkg::WIN_MASK) == rasm_pkg::PCR_BASE) begin
			win = rasm_pkg::RASM_WIN_PCR;
		end else if ((addr & rasm_pkg::GPIO_MASK) == rasm_pkg::GPIO_BASE) begin
			win = rasm_pkg::RASM_WIN_GPIO;
			in_gpio = (int'(addr[11:2]) < GPIO_COUNT);
		end else if ((addr & rasm_pkg::WIN_MASK) == rasm_pkg::GLOBAL_BASE) begin
			win = rasm_pkg::RASM_WIN_GLOBAL;
		end else begin
			win = rasm_pkg::RASM_WIN_NONE;
		end
	end
	logic glb;
	assign glb = (win == rasm_pkg::RASM_WIN_GLOBAL);
	assign gpio.idx   = addr[IW+1:2];
	assign gpio.we    = wrs && in_gpio;
	assign gpio.wdata = wdata;
	// Registered select so the next cycle routes memory data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gpio_rd <= 1'b0;
		end else begin
			gpio_rd <= rd && in_gpio;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			win_sel <= rasm_pkg::RASM_WIN_NONE;
		end else if (req) begin
			win_sel <= win;
		end
	end
	// writes to read-only ignored; rw updates only at OFF_RW, low 16 bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rw_ctrl <= rasm_pkg::RW_RESET;
		end else if (wrs && glb && off == rasm_pkg::OFF_RW) begin
			rw_ctrl <= wdata & rasm_pkg::RW_MASK;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wo_cmd       <= rasm_pkg::ZERO;
			wo_cmd_pulse <= 1'b0;
		end else begin
			wo_cmd_pulse <= wrs && glb && off == rasm_pkg::OFF_WO;
			if (wrs && glb && off == rasm_pkg::OFF_WO) begin
				wo_cmd <= wdata;
			end
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sor <= rasm_pkg::ZERO;
		end else if (rd && glb && off == rasm_pkg::OFF_SOR) begin
			sor <= ~rasm_pkg::ZERO;
		end else if (wrs && glb && off == rasm_pkg::OFF_SOR) begin
			sor <= rasm_pkg::ZERO;
		end
	end
	// clear after read, status sets win
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cor <= rasm_pkg::ZERO;
		end else if (rd && glb && off == rasm_pkg::OFF_COR) begin
			cor <= ro_status;
		end else begin
			cor <= cor | ro_status;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			w1c <= rasm_pkg::ZERO;
		end else if (wrs && glb && off == rasm_pkg::OFF_W1C) begin
			w1c <= (w1c & ~wdata) | ro_status;
		end else begin
			w1c <= w1c | ro_status;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			w0c <= rasm_pkg::ZERO;
		end else if (wrs && glb && off == rasm_pkg::OFF_W0C) begin
			w0c <= (w0c & wdata) | ro_status;
		end else begin
			w0c <= w0c | ro_status;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			w1s <= rasm_pkg::ZERO;
		end else if (wrs && glb && off == rasm_pkg::OFF_W1S) begin
			w1s <= w1s | wdata;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			w0s <= rasm_pkg::ZERO;
		end else if (wrs && glb && off == rasm_pkg::OFF_W0S) begin
			w0s <= w0s | ~wdata;
		end
	end
	// Factory field is writable; software is expected to leave it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			test_reg <= rasm_pkg::TEST_RESET;
		end else if (wrs && glb && off == rasm_pkg::OFF_TEST) begin
			test_reg <= wdata;
		end
	end
	always_comb begin
		next_rdata = rasm_pkg::ZERO;
		if (glb) begin
			case (off)
				rasm_pkg::OFF_RW:   next_rdata = rw_ctrl;
				rasm_pkg::OFF_RO:   next_rdata = ro_status;
				rasm_pkg::OFF_WO:   next_rdata = rasm_pkg::ZERO;
				rasm_pkg::OFF_SOR:  next_rdata = sor;
				rasm_pkg::OFF_COR:  next_rdata = cor;
				rasm_pkg::OFF_W1C:  next_rdata = w1c;
				rasm_pkg::OFF_W0C:  next_rdata = w0c;
				rasm_pkg::OFF_W1S:  next_rdata = w1s;
				rasm_pkg::OFF_W0S:  next_rdata = w0s;
				rasm_pkg::OFF_TEST: next_rdata = test_reg;
				default:            next_rdata = rasm_pkg::ZERO;
			endcase
		end
	end
	// every access completes, no stray state
	logic [31:0] rd_hold;
	logic        ack_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_hold <= rasm_pkg::ZERO;
			ack_q   <= 1'b0;
		end else begin
			ack_q   <= req;
			rd_hold <= rd ? next_rdata : rasm_pkg::ZERO;
		end
	end
	assign ack   = ack_q;
	assign rdata = gpio_rd ? gpio.rdata : rd_hold;
endmodule
`default_nettype wire

/* File: hdl/rasm_pkg.sv */
// Constants and types for the register access semantics map
package rasm_pkg;
	localparam logic [31:0] WDT_BASE    = 32'h4000_0000;
	localparam logic [31:0] DEBUG_BASE  = 32'h4008_0000;
	localparam logic [31:0] PCR_BASE    = 32'h4008_0100;
	localparam logic [31:0] GPIO_BASE   = 32'h4008_1000;
	localparam logic [31:0] GLOBAL_BASE = 32'h400F_FF00;
	localparam logic [31:0] WIN_MASK    = 32'hFFFF_FF00;
	localparam logic [31:0] GPIO_MASK   = 32'hFFFF_F000;
	// Word offsets inside the semantics demonstration window (global config)
	localparam logic [7:0] OFF_RW      = 8'h00;
	localparam logic [7:0] OFF_RO      = 8'h04;
	localparam logic [7:0] OFF_WO      = 8'h08;
	localparam logic [7:0] OFF_SOR     = 8'h0C;
	localparam logic [7:0] OFF_COR     = 8'h10;
	localparam logic [7:0] OFF_W1C     = 8'h14;
	localparam logic [7:0] OFF_W0C     = 8'h18;
	localparam logic [7:0] OFF_W1S     = 8'h1C;
	localparam logic [7:0] OFF_W0S     = 8'h20;
	localparam logic [7:0] OFF_TEST    = 8'h24;
	localparam logic [31:0] RW_RESET   = 32'h0000_0000;
	localparam logic [31:0] RW_MASK    = 32'h0000_FFFF;
	localparam logic [31:0] TEST_RESET = 32'h0000_0000;
	localparam logic [31:0] ZERO       = 32'h0000_0000;
	typedef enum logic [2:0] {
		RASM_WIN_NONE   = 3'h0,
		RASM_WIN_WDT    = 3'h1,
		RASM_WIN_DEBUG  = 3'h3,
		RASM_WIN_PCR    = 3'h2,
		RASM_WIN_GPIO   = 3'h6,
		RASM_WIN_GLOBAL = 3'h7
	} rasm_win_t;
endpackage

/* File: hdl/rasm_gpio_if.sv */
// Interface between the map and the GPIO configuration store
`timescale 1ns/1ps
`default_nettype none
interface rasm_gpio_if #(parameter int GPIO_COUNT = 128);
	logic                          we;
	logic [$clog2(GPIO_COUNT)-1:0] idx;
	logic [31:0]                   wdata;
	logic [31:0]                   rdata;
	modport map (output we, output idx, output wdata, input rdata);
	modport mem (input we, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

/* File: hdl/rasm_gpio_mem.sv */
// GPIO configuration store for the full GPIO complement
`timescale 1ns/1ps
`default_nettype none
module rasm_gpio_mem #(
	parameter int GPIO_COUNT = 128
) (
	input wire logic   clk,
	input wire logic   rst_n,
	rasm_gpio_if.mem   port
);
	logic [31:0] cfg [GPIO_COUNT];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < GPIO_COUNT; i++) begin
				cfg[i] <= rasm_pkg::ZERO;
			end
		end else if (port.we) begin
			cfg[port.idx] <= port.wdata;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port.rdata <= rasm_pkg::ZERO;
		end else begin
			port.rdata <= cfg[port.idx];
		end
	end
endmodule
`default_nettype wire

/* File: dv/rasm_map_chk.sv */
// Checker for the map's bus and window ports
`timescale 1ns/1ps
`default_nettype none
module rasm_map_chk (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        req,
	input wire logic        wr,
	input wire logic [31:0] addr,
	input wire logic [31:0] ro_status,
	input wire logic        ack,
	input wire logic [31:0] rdata,
	input wire logic [2:0]  win_sel,
	input wire logic [31:0] rw_ctrl
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic       g = req && !wr && addr[31:8] == rasm_pkg::GLOBAL_BASE[31:8];
	wire logic [7:0] o = addr[7:0];
	wire logic       s = g && o == rasm_pkg::OFF_SOR;
	property p_ack; req |=> ack; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_idle; !req |=> !ack && rdata == '0; endproperty
	a_idle: assert property (p_idle) else $error("stray answer");
	property p_ro; g && o == rasm_pkg::OFF_RO |=> rdata == $past(ro_status); endproperty
	a_ro: assert property (p_ro) else $error("status view wrong");
	property p_rsv; g && o > rasm_pkg::OFF_TEST |=> rdata == '0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved not zero");
	property p_sor; s ##1 s |=> &rdata; endproperty
	a_sor: assert property (p_sor) else $error("read did not set");
	property p_mask; rw_ctrl[31:16] == '0; endproperty
	a_mask: assert property (p_mask) else $error("upper control set");
	property p_hold; !(req && wr && addr == rasm_pkg::GLOBAL_BASE) |=> $stable(rw_ctrl); endproperty
	a_hold: assert property (p_hold) else $error("control moved");
	property p_pcr;
		req && addr[31:8] == rasm_pkg::PCR_BASE[31:8] |=> win_sel == rasm_pkg::RASM_WIN_PCR;
	endproperty
	a_pcr: assert property (p_pcr) else $error("power window");
	property p_wdt;
		req && addr[31:8] == rasm_pkg::WDT_BASE[31:8] |=> win_sel == rasm_pkg::RASM_WIN_WDT;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog window");
	c_wr: cover property (req && wr);
	c_sor: cover property (s ##1 s);
	c_cor: cover property (g && o == rasm_pkg::OFF_COR);
endmodule
bind rasm_map rasm_map_chk i_rasm_map_chk (.clk(clk), .rst_n(rst_n), .req(req), .wr(wr),
	.addr(addr), .ro_status(ro_status), .ack(ack), .rdata(rdata), .win_sel(win_sel),
	.rw_ctrl(rw_ctrl));
`default_nettype wire

/* File: dv/rasm_host.sv */
// Bus host model issuing single-word accesses
`timescale 1ns/1ps
`default_nettype none
module rasm_host (
	input  wire logic        clk,
	input  wire logic [31:0] rdata,
	output logic             req,
	output logic             wr,
	output logic [31:0]      addr,
	output logic [31:0]      wdata
);
	initial begin
		req = 1'b0;
		wr = 1'b0;
		addr = '0;
		wdata = '0;
	end
	task automatic acc(input logic w, input logic [31:0] a, d, output logic [31:0] q);
		req = 1'b1;
		wr = w;
		addr = a;
		wdata = d;
		@(posedge clk);
		@(negedge clk);
		q = rdata;
	endtask
	// Released addr and wdata lines flip; wr holds its value
	task automatic idle;
		req = 1'b0;
		addr = ~addr;
		wdata = ~wdata;
		@(negedge clk);
	endtask
endmodule
`default_nettype wire

/* File: dv/rasm_map_tb.sv */
// Self-checking bench for the register access map
`timescale 1ns/1ps
`default_nettype none
module rasm_map_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        req, wr, ack, pulse;
	logic [31:0] addr, wdata, rdata, rw_ctrl, wo_cmd, q;
	logic [31:0] ro_status = '0;
	logic [2:0]  win_sel;
	int          err_total = 0;
	int          check_count = 0;
	initial forever #25 clk = ~clk;
	rasm_map i_rasm_map (.clk(clk), .rst_n(rst_n), .req(req), .wr(wr), .addr(addr),
		.wdata(wdata), .ro_status(ro_status), .ack(ack), .rdata(rdata), .win_sel(win_sel),
		.rw_ctrl(rw_ctrl), .wo_cmd(wo_cmd), .wo_cmd_pulse(pulse));
	rasm_host i_rasm_host (.clk(clk), .rdata(rdata), .req(req), .wr(wr), .addr(addr),
		.wdata(wdata));
	task automatic chk(input logic [31:0] got, exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] g(input logic [7:0] o);
		return rasm_pkg::GLOBAL_BASE | 32'(o);
	endfunction
	task automatic wr_w(input logic [31:0] a, d);
		i_rasm_host.acc(1'b1, a, d, q);
	endtask
	task automatic rd_w(input logic [31:0] a, e);
		i_rasm_host.acc(1'b0, a, '0, q);
		chk(q, e);
	endtask
	task automatic conclude;
		if (err_total == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic t_rsv;
		wr_w(g(8'h28), '1);
		rd_w(g(8'h28), '0);
		rd_w(g(rasm_pkg::OFF_RW), rasm_pkg::RW_RESET);
		wr_w(32'h5000_0000, '1);
		rd_w(32'h5000_0000, '0);
		chk(32'(win_sel), 32'(rasm_pkg::RASM_WIN_NONE));
		rd_w(g(rasm_pkg::OFF_TEST), rasm_pkg::TEST_RESET);
		chk(32'(win_sel), 32'(rasm_pkg::RASM_WIN_GLOBAL));
	endtask
	task automatic t_win;
		rd_w(rasm_pkg::WDT_BASE, '0);
		chk(32'(win_sel), 32'(rasm_pkg::RASM_WIN_WDT));
		rd_w(rasm_pkg::DEBUG_BASE, '0);
		chk(32'(win_sel), 32'(rasm_pkg::RASM_WIN_DEBUG));
		rd_w(rasm_pkg::PCR_BASE, '0);
		chk(32'(win_sel), 32'(rasm_pkg::RASM_WIN_PCR));
	endtask
	task automatic t_sem;
		wr_w(g(rasm_pkg::OFF_RW), '1);
		rd_w(g(rasm_pkg::OFF_RW), rasm_pkg::RW_MASK);
		wr_w(g(rasm_pkg::OFF_WO), 32'h1234_5678);
		chk(32'(pulse), 32'h0000_0001);
		rd_w(g(rasm_pkg::OFF_WO), '0);
		chk(32'(pulse), 32'h0000_0000);
		chk(wo_cmd, 32'h1234_5678);
		rd_w(g(rasm_pkg::OFF_SOR), '0);
		rd_w(g(rasm_pkg::OFF_SOR), '1);
	endtask
	task automatic t_flags;
		ro_status = 32'hA5C3_0F0F;
		wr_w(g(rasm_pkg::OFF_RO), '0);
		rd_w(g(rasm_pkg::OFF_RO), 32'hA5C3_0F0F);
		ro_status = '0;
		wr_w(g(rasm_pkg::OFF_COR), '1);
		rd_w(g(rasm_pkg::OFF_COR), 32'hA5C3_0F0F);
		rd_w(g(rasm_pkg::OFF_COR), '0);
		wr_w(g(rasm_pkg::OFF_W1C), 32'h0000_00FF);
		rd_w(g(rasm_pkg::OFF_W1C), 32'hA5C3_0F00);
		wr_w(g(rasm_pkg::OFF_W0C), 32'hFFFF_0000);
		rd_w(g(rasm_pkg::OFF_W0C), 32'hA5C3_0000);
		wr_w(g(rasm_pkg::OFF_W1S), 32'h0F0F_0000);
		wr_w(g(rasm_pkg::OFF_W1S), '0);
		rd_w(g(rasm_pkg::OFF_W1S), 32'h0F0F_0000);
		wr_w(g(rasm_pkg::OFF_W0S), 32'hFFFF_FF00);
		wr_w(g(rasm_pkg::OFF_W0S), '1);
		rd_w(g(rasm_pkg::OFF_W0S), 32'h0000_00FF);
		// Event in the clearing cycle must survive
		ro_status = 32'h0000_0001;
		wr_w(g(rasm_pkg::OFF_W1C), '1);
		ro_status = '0;
		rd_w(g(rasm_pkg::OFF_W1C), 32'h0000_0001);
	endtask
	task automatic t_gpio;
		wr_w(rasm_pkg::GPIO_BASE, 32'h0000_0001);
		wr_w(rasm_pkg::GPIO_BASE + 32'h0000_01FC, 32'h8765_4321);
		rd_w(rasm_pkg::GPIO_BASE + 32'h0000_01FC, 32'h8765_4321);
		rd_w(rasm_pkg::GPIO_BASE, 32'h0000_0001);
		chk(32'(win_sel), 32'(rasm_pkg::RASM_WIN_GPIO));
		rd_w(rasm_pkg::GPIO_BASE + 32'h0000_0200, '0);
		i_rasm_host.idle();
	endtask
	task automatic t_idle;
		rd_w(g(rasm_pkg::OFF_RW), rasm_pkg::RW_MASK);
		chk(32'(ack), 32'h0000_0001);
		i_rasm_host.idle();
		chk(32'(ack), 32'h0000_0000);
		chk(rdata, '0);
		i_rasm_host.idle();
	endtask
	initial begin
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		t_rsv();
		t_win();
		t_sem();
		t_flags();
		t_gpio();
		t_idle();
		conclude();
	end
	// Run needs under 100 cycles
	initial begin
		repeat (500) @(posedge clk);
		err_total++;
		conclude();
	end
endmodule
`default_nettype wire
